// >>> design/dacsr_regs.vh
// Purpose: Constants for the dual converter control and serial readout.
// Assumes: Included by the design files of this block only.
// Notes:   Times in ns; counts in serial bit clock cycles.
`ifndef DACSR_REGS_VH
`define DACSR_REGS_VH

`define DACSR_SYS_PERIOD_NS   40
`define DACSR_FRAME_CLKS      20
`define DACSR_CONV_CLKS       16
`define DACSR_ACQ_CLKS        4
`define DACSR_CONV_TIME_NS    1600
`define DACSR_ACQ_TIME_NS     400
`define DACSR_REF_CKP_NS      100
`define DACSR_DATA_BITS       16
`define DACSR_ID_BITS         4
`define DACSR_WORD_BITS       20
`define DACSR_LATCH_CLK       2
`define DACSR_BUSY_DROP_BIT   3
`define DACSR_ID_A0           4'h0
`define DACSR_ID_A1           4'h1
`define DACSR_ID_B0           4'h2
`define DACSR_ID_B1           4'h3

`endif

// >>> design/dacsr_result_mem.v
// Purpose: Holds the latest 16-bit conversion result of each of the four channels.
// Assumes: One write port and one read port on clk_sys.
// Notes:   Read data come out of a register, one cycle after the address.
`timescale 1ns/1ns
`include "dacsr_regs.vh"

module dacsr_result_mem (
	input  wire        clk_sys,
	input  wire        wr_en,
	input  wire [1:0]  wr_addr,
	input  wire [15:0] wr_data,
	input  wire [1:0]  rd_addr,
	output reg  [15:0] rd_data_q
);

	reg [15:0] mem_q [0:3];

	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		rd_data_q <= mem_q[rd_addr];
	end

endmodule

// >>> design/dacsr_top.v
// Purpose: Control and serial readout of a dual simultaneous 16-bit converter.
// Assumes: Host pins arrive asynchronously and are synchronised to clk_sys;
//          the serial bit clock is sampled, not used as a clock.
// Notes:   Conversion results arrive as parallel words from the analog core.
`timescale 1ns/1ns
`include "dacsr_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Two-channel mode converts pair 1 when pair_select high, else pair 0.
// - Trigger rising edge puts both sample-and-holds into hold at once.
// - Host readout sync rising edge starts a serial frame; word aligns to it.
// - Word is channel id then 16 data bits, 20 bit clocks after sync.
// - Chip select low drives output A, and output B unless merged; high tri-states both.
// - Busy rises at conversion start, falls after third LSB shifted out.
// - Merge select high sends A then B results on serial output A.
// - Conversion needs 16 bit clocks, acquisition 4, per 20-clock frame.
// - Address and mode latched on falling edge of second conversion clock.
// - Sync and chip select are sampled on a falling bit clock edge.
// - Output bits change after a rising bit clock edge, held till then.
// - Merge low uses both outputs; merge high keeps output B tri-stated.
// - Four-channel mode converts pair 0 then pair 1, ignoring pair_select.
module dacsr_top (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        serial_bit_clock,
	input  wire        conversion_trigger,
	input  wire        readout_sync,
	input  wire        chip_select_n,
	input  wire        pair_select,
	input  wire        channel_count_select,
	input  wire        output_merge_select,
	input  wire [15:0] result_a,
	input  wire [15:0] result_b,
	output reg         hold_q,
	output reg         busy_q,
	output reg  [1:0]  pair_conv_q,
	output reg         sdo_a_q,
	output reg         sdo_a_oe_n_q,
	output reg         sdo_b_q,
	output reg         sdo_b_oe_n_q
);

	localparam ST_IDLE = 3'b001;
	localparam ST_CONV = 3'b010;
	localparam ST_ACQ  = 3'b100;

	localparam [4:0] CONV_CLKS = `DACSR_CONV_CLKS;
	localparam [4:0] FRAME_CLKS = `DACSR_FRAME_CLKS;
	localparam [5:0] WORD_BITS = `DACSR_WORD_BITS;
	localparam [1:0] LATCH_CLK = `DACSR_LATCH_CLK;
	localparam [5:0] BUSY_BIT  = `DACSR_BUSY_DROP_BIT;
	// Bit position (from word start) of the third LSB.
	localparam [5:0] BUSY_DROP = WORD_BITS - BUSY_BIT;

	////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for the seven host control pin inputs.
	reg  [6:0] sync1_q;
	reg  [6:0] sync2_q;
	reg        bclk_d1_q;
	reg        trig_d1_q;
	reg        rsync_d1_q;

	always @(posedge clk_sys) begin
		sync1_q <= {serial_bit_clock, conversion_trigger, readout_sync,
			chip_select_n, pair_select, channel_count_select,
			output_merge_select};
		sync2_q <= sync1_q;
		if (!rst_n) begin
			bclk_d1_q  <= 1'b0;
			trig_d1_q  <= 1'b0;
			rsync_d1_q <= 1'b0;
		end else begin
			bclk_d1_q  <= sync2_q[6];
			trig_d1_q  <= sync2_q[5];
			rsync_d1_q <= sync2_q[4];
		end
	end

	wire bclk_s  = sync2_q[6];
	wire trig_s  = sync2_q[5];
	wire rsync_s = sync2_q[4];
	wire cs_n_s  = sync2_q[3];
	wire psel_s  = sync2_q[2];
	wire ccnt_s  = sync2_q[1];
	wire merge_s = sync2_q[0];

	wire bclk_rise = bclk_s & ~bclk_d1_q;
	wire bclk_fall = ~bclk_s & bclk_d1_q;
	wire trig_rise = trig_s & ~trig_d1_q;

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer.
	reg  [2:0]  state_q;
	reg  [4:0]  clk_cnt_q;
	reg         four_ch_q;
	reg         psel_q;
	reg         merge_q;
	reg         second_pair_q;
	reg         mem_wr_q;
	reg  [1:0]  mem_addr_q;
	reg  [15:0] mem_data_q;
	reg         wr_b_pend_q;

	// The chained second pair of a four-channel run keeps the settings taken
	// for the first pair; a fresh latch there would restart the sequence.
	wire        latch_now = bclk_fall &&
		clk_cnt_q == {3'h0, LATCH_CLK} - 5'h01 &&
		!(four_ch_q && second_pair_q);

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q       <= ST_IDLE;
			clk_cnt_q     <= 5'h00;
			hold_q        <= 1'b0;
			four_ch_q     <= 1'b0;
			psel_q        <= 1'b0;
			merge_q       <= 1'b0;
			second_pair_q <= 1'b0;
			pair_conv_q   <= 2'h0;
			mem_wr_q      <= 1'b0;
			mem_addr_q    <= 2'h0;
			mem_data_q    <= 16'h0000;
			wr_b_pend_q   <= 1'b0;
		end else begin
			mem_wr_q <= 1'b0;
			if (wr_b_pend_q) begin
				mem_wr_q    <= 1'b1;
				mem_addr_q  <= {1'b1, second_pair_q};
				mem_data_q  <= result_b;
				wr_b_pend_q <= 1'b0;
			end
			case (state_q)
			ST_IDLE: begin
				if (trig_rise) begin
					hold_q    <= 1'b1;
					clk_cnt_q <= 5'h00;
					four_ch_q <= 1'b0;
					state_q   <= ST_CONV;
				end
			end
			ST_CONV: begin
				if (latch_now) begin
					four_ch_q <= ccnt_s;
					psel_q    <= psel_s;
					merge_q   <= merge_s;
					if (ccnt_s) begin
						second_pair_q <= 1'b0;
						pair_conv_q   <= 2'h1;
					end else begin
						second_pair_q <= psel_s;
						pair_conv_q   <= psel_s ? 2'h2 : 2'h1;
					end
				end
				if (bclk_rise) begin
					clk_cnt_q <= clk_cnt_q + 5'h01;
					if (clk_cnt_q == CONV_CLKS - 5'h01) begin
						// Results are stored after all 16 conversion clocks.
						hold_q      <= 1'b0;
						mem_wr_q    <= 1'b1;
						mem_addr_q  <= {1'b0, second_pair_q};
						mem_data_q  <= result_a;
						wr_b_pend_q <= 1'b1;
						state_q     <= ST_ACQ;
					end
				end
			end
			ST_ACQ: begin
				if (bclk_rise) begin
					clk_cnt_q <= clk_cnt_q + 5'h01;
					if (clk_cnt_q == FRAME_CLKS - 5'h01) begin
						clk_cnt_q <= 5'h00;
						if (four_ch_q && !second_pair_q) begin
							// Second pair follows without a new trigger.
							second_pair_q <= 1'b1;
							pair_conv_q   <= 2'h2;
							hold_q        <= 1'b1;
							state_q       <= ST_CONV;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial readout.
	reg         frame_q;
	reg  [5:0]  bit_cnt_q;
	reg         part_b_q;
	reg  [1:0]  rd_addr_q;
	wire [15:0] rd_data;
	reg  [15:0] shreg_a_q;
	reg  [15:0] shreg_b_q;
	reg  [3:0]  id_a_q;
	reg  [3:0]  id_b_q;
	reg         rsync_seen_q;
	reg         load_q;
	reg         load_dly_q;

	dacsr_result_mem u_mem (
		.clk_sys   (clk_sys),
		.wr_en     (mem_wr_q),
		.wr_addr   (mem_addr_q),
		.wr_data   (mem_data_q),
		.rd_addr   (rd_addr_q),
		.rd_data_q (rd_data)
	);

	wire [3:0] id_a = second_pair_q ? `DACSR_ID_A1 : `DACSR_ID_A0;
	wire [3:0] id_b = second_pair_q ? `DACSR_ID_B1 : `DACSR_ID_B0;
	wire [5:0] word_end = merge_q ? (WORD_BITS << 1) : WORD_BITS;
	wire [4:0] bit_pos = (bit_cnt_q >= WORD_BITS) ?
		bit_cnt_q[4:0] - WORD_BITS[4:0] : bit_cnt_q[4:0];
	wire       out_a = (bit_pos < `DACSR_ID_BITS) ?
		id_a_q[3 - bit_pos[1:0]] : shreg_a_q[15];
	wire       out_b = (bit_pos < `DACSR_ID_BITS) ?
		id_b_q[3 - bit_pos[1:0]] : shreg_b_q[15];

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			frame_q      <= 1'b0;
			bit_cnt_q    <= 6'h00;
			part_b_q     <= 1'b0;
			rd_addr_q    <= 2'h0;
			shreg_a_q    <= 16'h0000;
			shreg_b_q    <= 16'h0000;
			id_a_q       <= 4'h0;
			id_b_q       <= 4'h0;
			rsync_seen_q <= 1'b0;
			load_q       <= 1'b0;
			load_dly_q   <= 1'b0;
			busy_q       <= 1'b0;
			sdo_a_q      <= 1'b0;
			sdo_b_q      <= 1'b0;
			sdo_a_oe_n_q <= 1'b1;
			sdo_b_oe_n_q <= 1'b1;
		end else begin
			load_q     <= 1'b0;
			load_dly_q <= load_q;
			// A sync edge is armed when seen and taken on the next falling bit clock
			// edge with chip select low, so a pulse between edges still starts a frame.
			if (bclk_fall && rsync_seen_q) begin
				rsync_seen_q <= 1'b0;
				if (!cs_n_s) begin
					frame_q   <= 1'b1;
					bit_cnt_q <= 6'h00;
					part_b_q  <= 1'b0;
					rd_addr_q <= {1'b0, second_pair_q};
					load_q    <= 1'b1;
				end
			end
			// A new sync edge in the cycle that takes the old one stays armed.
			if (rsync_s && !rsync_d1_q) begin
				rsync_seen_q <= 1'b1;
			end
			if (load_dly_q) begin
				// The address changes with load_q and the memory registers its
				// output, so the addressed word is valid one cycle later.
				if (part_b_q) begin
					shreg_a_q <= rd_data;
				end else begin
					shreg_a_q <= rd_data;
					rd_addr_q <= {1'b1, second_pair_q};
					part_b_q  <= 1'b1;
				end
				id_a_q <= part_b_q ? id_b : id_a;
				id_b_q <= id_b;
			end
			if (part_b_q && !load_q && frame_q && bit_cnt_q == 6'h00) begin
				shreg_b_q <= rd_data;
			end
			if (frame_q && bclk_rise) begin
				sdo_a_q   <= out_a;
				sdo_b_q   <= out_b;
				bit_cnt_q <= bit_cnt_q + 6'h01;
				if (bit_pos >= `DACSR_ID_BITS) begin
					shreg_a_q <= {shreg_a_q[14:0], 1'b0};
					shreg_b_q <= {shreg_b_q[14:0], 1'b0};
				end
				if (bit_cnt_q == BUSY_DROP) begin
					busy_q <= 1'b0;
				end
				if (merge_q && bit_cnt_q == WORD_BITS - 6'h01) begin
					rd_addr_q <= {1'b1, second_pair_q};
					load_q    <= 1'b1;
				end
				if (bit_cnt_q == word_end - 6'h01) begin
					frame_q <= 1'b0;
				end
			end
			// A trigger in the cycle of the drop point wins, so busy never
			// hides a conversion that has just begun.
			if (trig_rise) begin
				busy_q <= 1'b1;
			end
			sdo_a_oe_n_q <= cs_n_s;
			sdo_b_oe_n_q <= cs_n_s | merge_q;
		end
	end

endmodule

// >>> test/dacsr_checker.sv
// Purpose: Port assertions for the converter control block.
// Assumes: Bit clock period near ten system clocks.
// Notes:   Attached by bind below the module.
`timescale 1ns/1ns
module dacsr_checker (
	input wire       clk_sys,
	input wire       rst_n,
	input wire       serial_bit_clock,
	input wire       conversion_trigger,
	input wire       chip_select_n,
	input wire       pair_select,
	input wire       channel_count_select,
	input wire       output_merge_select,
	input wire       hold_q,
	input wire       busy_q,
	input wire [1:0] pair_conv_q,
	input wire       sdo_a_q,
	input wire       sdo_a_oe_n_q,
	input wire       sdo_b_oe_n_q
);
	reg       bclk_q;
	reg [4:0] rise_q;
	reg [7:0] since_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Pin edges are counted raw, so the bounds allow for input sync lag.
	always @(posedge clk_sys) begin
		bclk_q <= serial_bit_clock;
		if (!rst_n || !hold_q)
			rise_q <= 5'h0;
		else if (serial_bit_clock && !bclk_q)
			rise_q <= rise_q + 5'h1;
		if (!rst_n || (serial_bit_clock && !bclk_q))
			since_q <= 8'h0;
		else if (since_q != 8'hff)
			since_q <= since_q + 8'h1;
	end
	a_cs_off_float:
		assert property (chip_select_n [*6] |-> sdo_a_oe_n_q && sdo_b_oe_n_q)
		else $error("serial output driven while deselected");
	a_merge_b_off:
		assert property (output_merge_select [*6] |-> sdo_b_oe_n_q)
		else $error("output b driven in merge mode");
	a_hold_busy:
		assert property ($rose(hold_q) |-> busy_q)
		else $error("hold without busy");
	a_hold_cause:
		assert property ($rose(hold_q) && !channel_count_select |->
			$past(conversion_trigger, 2)) else $error("hold without trigger");
	a_hold_length:
		assert property ($fell(hold_q) |-> rise_q >= 5'hf && rise_q <= 5'h11)
		else $error("conversion length wrong");
	a_pair_latch:
		assert property ($fell(hold_q) && !channel_count_select |->
			pair_conv_q == (pair_select ? 2'h2 : 2'h1))
		else $error("wrong pair converted");
	a_sdo_edge:
		assert property ($changed(sdo_a_q) && !sdo_a_oe_n_q |-> since_q <= 8'h7)
		else $error("data changed away from rising clock");
	a_busy_drop:
		assert property ($fell(busy_q) |-> !hold_q && since_q <= 8'h7)
		else $error("busy fell off a shift edge");
endmodule
bind dacsr_top dacsr_checker u_chk (.*);

// >>> test/dacsr_host_model.sv
// Purpose: Host side: bit clock, trigger, readout sync, bit capture.
// Assumes: cmd 1 converts, 2 reads, 3 reads with chip select high.
// Notes:   Bits are taken on falling bit clock edges.
`timescale 1ns/1ns
module dacsr_host_model (
	input  wire        clk_sys,
	input  wire [1:0]  cmd,
	input  wire        pin_a,
	input  wire        pin_b,
	output reg         bclk,
	output reg         trig,
	output reg         sync,
	output reg         cs_n,
	output reg         done,
	output reg  [39:0] word_a,
	output reg  [19:0] word_b
);
	reg [1:0] c;
	integer   k;
	// The converter needs its clock all the time, so it never stops.
	initial begin
		bclk = 1'b0;
		forever begin
			repeat (5) @(posedge clk_sys);
			bclk <= ~bclk;
		end
	end
	initial begin
		{trig, sync, cs_n, done} = 4'h2;
		word_a = 40'h0;
		word_b = 20'h0;
		forever begin
			@(posedge clk_sys);
			c = cmd;
			if (c != 2'h0) begin
				@(negedge bclk);
				trig <= (c == 2'h1);
				cs_n <= (c != 2'h2);
				@(negedge bclk);
				trig <= 1'b0;
				sync <= (c != 2'h1);
				@(negedge bclk);
				sync <= 1'b0;
				for (k = 0; k < 40; k = k + 1) begin
					@(negedge bclk);
					word_a <= {word_a[38:0], pin_a};
					if (k < 20)
						word_b <= {word_b[18:0], pin_b};
				end
				cs_n <= 1'b1;
				done <= 1'b1;
				@(posedge clk_sys);
				done <= 1'b0;
			end
		end
	end
endmodule

// >>> test/dacsr_top_bench.sv
// Purpose: Self-checking bench for dacsr_top with a host model.
// Assumes: Core results are random and held until read back.
// Notes:   Four of the eight mode combinations each convert once and read back.
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
	num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module dacsr_top_bench;
	reg         clk_sys, rst_n, ps, ccs, oms;
	reg  [15:0] ra, rb;
	reg  [1:0]  cmd;
	wire        bclk, trig, sync, cs_n, done, hold_q, busy_q;
	wire        sa, sa_oe_n, sb, sb_oe_n, pin_a, pin_b;
	wire [1:0]  pair_q;
	wire [39:0] word_a;
	wire [19:0] word_b;
	integer     num_errors, check_count, seed, cyc, i, p;
	reg  [39:0] exp_w;
	reg  [39:0] exp_q[$];
	// A released line shows the inverse of its last bit, never a kind level.
	assign pin_a = sa_oe_n ? ~sa : sa;
	assign pin_b = sb_oe_n ? ~sb : sb;
	dacsr_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .serial_bit_clock(bclk),
		.conversion_trigger(trig), .readout_sync(sync), .chip_select_n(cs_n),
		.pair_select(ps), .channel_count_select(ccs),
		.output_merge_select(oms), .result_a(ra), .result_b(rb),
		.hold_q(hold_q), .busy_q(busy_q), .pair_conv_q(pair_q), .sdo_a_q(sa),
		.sdo_a_oe_n_q(sa_oe_n), .sdo_b_q(sb), .sdo_b_oe_n_q(sb_oe_n));
	dacsr_host_model host (.clk_sys(clk_sys), .cmd(cmd), .pin_a(pin_a),
		.pin_b(pin_b), .bclk(bclk), .trig(trig), .sync(sync), .cs_n(cs_n),
		.done(done), .word_a(word_a), .word_b(word_b));
	task print_verdict;
		begin
			if (num_errors == 0 && check_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task run(input [1:0] c);
		begin
			cmd <= c;
			@(posedge clk_sys);
			cmd <= 2'h0;
			@(posedge done);
			@(posedge clk_sys);
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 10000) begin
			num_errors = num_errors + 1;
			print_verdict;
		end
	end
	initial begin
		{rst_n, ps, ccs, oms, cmd, ra, rb} = '0;
		num_errors = 0;
		check_count = 0;
		seed = 32'h6892;
		cyc = 0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			ps <= i[0];
			oms <= i[1];
			ccs <= (i == 2);
			ra <= $random(seed);
			rb <= $random(seed);
			p = (i == 2) ? 1 : i % 2;
			run(2'h1);
			exp_q.push_back({p[3:0], ra, p[3:0] + 4'h2, rb});
			`CHK("pair", p[1:0] + 2'h1, pair_q)
			`CHK("busy", 1'b1, busy_q)
			if (i == 1) begin
				run(2'h3);
				`CHK("busy", 1'b1, busy_q)
			end
			run(2'h2);
			exp_w = exp_q.pop_front();
			if (oms)
				`CHK("merged", exp_w, word_a)
			else
				`CHK("word_a", exp_w[39:20], word_a[39:20])
			if (!oms)
				`CHK("word_b", exp_w[19:0], word_b)
			`CHK("busy", 1'b0, busy_q)
		end
		print_verdict;
	end
endmodule
